// ### verilog/wake_event_status_aggregator.sv
// wake_event_status_aggregator.sv: sticky wake status, enables and wake request output
// assumes: register accesses come from decode logic on i_clk, already relative to the
// runtime base; wake event lines are asynchronous and pass two flip-flops here;
// i_rst_b is the standby-power power-on reset, other resets do not reach this block
`timescale 1ns/1ps

module wake_event_status_aggregator
  import wake_agg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire logic i_ring_indicate_port2,
  input wire logic i_ring_indicate_port1,
  input wire logic i_keyboard_wake,
  input wire logic i_mouse_wake,
  input wire logic i_specific_key_wake,
  input wire logic i_wake_a,
  input wire logic i_wake_b,
  input wire logic [7:0] i_gpio_group1,
  input wire logic [2:0] i_gpio_group2_low,
  input wire logic i_group_smi_wake_status,
  input wire logic [3:0] i_gpio_group2_high,
  input wire logic [3:0] i_gpio_group3,
  input wire logic i_gpio_group4_pin1,
  input wire logic i_gpio_group4_pin3,
  input wire logic i_gpio_group6_pin0,
  input wire logic i_gpio_group6_pin1,
  input wire logic [7:0] i_gpio_group5,
  output logic o_wake_request_n
);

  // ---------------------------------------------------------------
  // event mapping and synchronisers
  // ---------------------------------------------------------------

  // pack raw event lines into register bit order
  wake_vec_t raw_events;
  assign raw_events[0] = {i_wake_b, i_wake_a, i_specific_key_wake, i_mouse_wake,
                          i_keyboard_wake, i_ring_indicate_port1, i_ring_indicate_port2,
                          1'b0};
  assign raw_events[1] = i_gpio_group1;
  assign raw_events[2] = {i_gpio_group2_high, i_group_smi_wake_status, i_gpio_group2_low};
  assign raw_events[3] = {i_gpio_group6_pin1, i_gpio_group6_pin0, i_gpio_group4_pin3,
                          i_gpio_group4_pin1, i_gpio_group3};
  assign raw_events[4] = i_gpio_group5;

  // two-stage synchroniser for pin inputs
  wake_vec_t sync1_reg;
  wake_vec_t sync2_reg;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw_events;
      sync2_reg <= sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------

  // write strobes per register
  wire wr_summary = i_req.wr && (i_req.addr == `OFS_SUMMARY);
  wire wr_out_en = i_req.wr && (i_req.addr == `OFS_OUT_EN);
  wire [NUM_GROUPS-1:0] wr_sts;
  wire [NUM_GROUPS-1:0] wr_en;
  assign wr_sts[0] = i_req.wr && (i_req.addr == `OFS_STS_DEVICES);
  assign wr_sts[1] = i_req.wr && (i_req.addr == `OFS_STS_GRP1);
  assign wr_sts[2] = i_req.wr && (i_req.addr == `OFS_STS_GRP2);
  assign wr_sts[3] = i_req.wr && (i_req.addr == `OFS_STS_MIXED);
  assign wr_sts[4] = i_req.wr && (i_req.addr == `OFS_STS_GRP5);
  assign wr_en[0] = i_req.wr && (i_req.addr == `OFS_EN_DEVICES);
  assign wr_en[1] = i_req.wr && (i_req.addr == `OFS_EN_GRP1);
  assign wr_en[2] = i_req.wr && (i_req.addr == `OFS_EN_GRP2);
  assign wr_en[3] = i_req.wr && (i_req.addr == `OFS_EN_MIXED);
  assign wr_en[4] = i_req.wr && (i_req.addr == `OFS_EN_GRP5);

  // ---------------------------------------------------------------
  // status, enable and summary state
  // ---------------------------------------------------------------

  wake_vec_t sts_reg;
  wake_vec_t sts_next;
  wake_vec_t en_reg;
  logic out_en_reg;
  logic summary_reg;
  logic summary_next;
  logic [NUM_GROUPS-1:0] grp_pending;
  wire [7:0] dev_mask = 8'hFE; // devices bit 0 is reserved

  // sticky status: set wins over write-one-to-clear
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++)
    begin : g_sts
      wire [7:0] valid_mask = (g == 0) ? dev_mask : 8'hFF;
      wire [7:0] clr = wr_sts[g] ? i_req.wdata : 8'h00;
      assign sts_next[g] = ((sts_reg[g] & ~clr) | sync2_reg[g]) & valid_mask;
      assign grp_pending[g] = |(sts_reg[g] & en_reg[g] & valid_mask);
    end
  endgenerate

  // request condition before the output enable gate
  wire would_request = |grp_pending;
  wire clr_summary = wr_summary && i_req.wdata[`FLAG_BIT];
  // flag sets on the would-request condition; a clear wins, and a condition still present sets the flag again one cycle later
  assign summary_next = (summary_reg && !clr_summary) || (would_request && !summary_reg);

  // standby reset is the only reset of this state
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sts_reg <= '0;
      en_reg <= '0;
      out_en_reg <= `RST_BIT;
      summary_reg <= `RST_BIT;
    end
    else
    begin
      sts_reg <= sts_next;
      summary_reg <= summary_next;
      if (wr_out_en)
        out_en_reg <= i_req.wdata[`FLAG_BIT];
      for (int k = 0; k < NUM_GROUPS; k++)
        if (wr_en[k])
          en_reg[k] <= i_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // wake request output and read data
  // ---------------------------------------------------------------

  // active low request, held off by output enable and by a cleared flag
  logic req_n_reg;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      req_n_reg <= 1'b1;
    else
      req_n_reg <= !(out_en_reg && summary_next && would_request);
  end
  assign o_wake_request_n = req_n_reg;

  // read multiplexer; reserved offsets and upper bits give zero
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (i_req.addr)
      `OFS_SUMMARY: rd_mux = {7'h00, summary_reg};
      `OFS_OUT_EN: rd_mux = {7'h00, out_en_reg};
      `OFS_STS_DEVICES: rd_mux = sts_reg[0];
      `OFS_STS_GRP1: rd_mux = sts_reg[1];
      `OFS_STS_GRP2: rd_mux = sts_reg[2];
      `OFS_STS_MIXED: rd_mux = sts_reg[3];
      `OFS_STS_GRP5: rd_mux = sts_reg[4];
      `OFS_EN_DEVICES: rd_mux = en_reg[0] & dev_mask;
      `OFS_EN_GRP1: rd_mux = en_reg[1];
      `OFS_EN_GRP2: rd_mux = en_reg[2];
      `OFS_EN_MIXED: rd_mux = en_reg[3];
      `OFS_EN_GRP5: rd_mux = en_reg[4];
      default: rd_mux = 8'h00;
    endcase
  end

  // registered read data, one cycle after the read strobe
  logic [7:0] rdata_reg;
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      rdata_reg <= 8'h00;
    else if (i_req.rd)
      rdata_reg <= rd_mux;
  end
  assign o_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_req_needs_enable: assert property (!out_en_reg |=> o_wake_request_n)
    else $error("wake request active while output enable is zero");
  a_flag_on_request: assert property (would_request && !summary_reg |=> summary_reg)
    else $error("summary flag not set on pending wake");
  a_flag_w1c: assert property (summary_reg && clr_summary && !would_request |=> !summary_reg)
    else $error("summary flag not cleared by write one");
  a_flag_w0_keeps: assert property (summary_reg && !clr_summary |=> summary_reg)
    else $error("summary flag lost without a clear");
  a_req_follows: assert property (out_en_reg && summary_reg && would_request && !clr_summary
                                  && !wr_out_en |=> !o_wake_request_n)
    else $error("wake request missing with all conditions met");
  a_status_sets: assert property (sync2_reg[1][0] |=> sts_reg[1][0])
    else $error("status bit not set by event");
  a_status_holds: assert property (sts_reg[4][2] && !(wr_sts[4] && i_req.wdata[2]) |=> sts_reg[4][2])
    else $error("status bit dropped without clear");
  a_status_w1c: assert property (wr_sts[2] && i_req.wdata[5] && !sync2_reg[2][5] |=> !sts_reg[2][5])
    else $error("status bit not cleared by write one");
  a_reserved_zero: assert property (i_req.rd && i_req.addr == `OFS_RSVD_NINE |=> o_rdata == 8'h00)
    else $error("reserved offset read not zero");
  a_dev_bit0_zero: assert property (sts_reg[0][`STS_DEV_RSVD_BIT] == 1'b0)
    else $error("reserved devices bit set");

  // upper bits and reserved offsets read as zero
  a_flag_upper_zero: assert property (i_req.rd && i_req.addr == `OFS_SUMMARY |=> o_rdata[7:1] == 7'h00)
    else $error("summary register upper bits not zero");
  a_en_upper_zero: assert property (i_req.rd && i_req.addr == `OFS_OUT_EN |=> o_rdata[7:1] == 7'h00)
    else $error("output enable register upper bits not zero");
  a_rsvd_one_zero: assert property (i_req.rd && i_req.addr == `OFS_RSVD_ONE |=> o_rdata == 8'h00)
    else $error("reserved offset one read not zero");
  a_rsvd_three_zero: assert property (i_req.rd && i_req.addr == `OFS_RSVD_THREE |=> o_rdata == 8'h00)
    else $error("reserved offset three read not zero");

  // request released by a flag clear and never raised without a pending source
  a_clear_drops_req: assert property (summary_reg && clr_summary |=> o_wake_request_n)
    else $error("wake request still active after flag clear");
  a_req_needs_status: assert property (!would_request |=> o_wake_request_n)
    else $error("wake request active with nothing pending");

  // devices register: pin held at a sampling edge is latched three edges later
  a_ring2_map: assert property (i_ring_indicate_port2 |-> ##3 sts_reg[0][1])
    else $error("devices event not latched");
  a_ring1_map: assert property (i_ring_indicate_port1 |-> ##3 sts_reg[0][2])
    else $error("devices event not latched");
  a_keyboard_map: assert property (i_keyboard_wake |-> ##3 sts_reg[0][3])
    else $error("devices event not latched");
  a_mouse_map: assert property (i_mouse_wake |-> ##3 sts_reg[0][4])
    else $error("devices event not latched");
  a_spec_key_map: assert property (i_specific_key_wake |-> ##3 sts_reg[0][5])
    else $error("devices event not latched");
  a_wake_a_map: assert property (i_wake_a |-> ##3 sts_reg[0][6])
    else $error("devices event not latched");
  a_wake_b_map: assert property (i_wake_b |-> ##3 sts_reg[0][7])
    else $error("devices event not latched");

  // group one register
  a_grp1_bit0: assert property (i_gpio_group1[0] |-> ##3 sts_reg[1][0])
    else $error("group one event not latched");
  a_grp1_bit1: assert property (i_gpio_group1[1] |-> ##3 sts_reg[1][1])
    else $error("group one event not latched");
  a_grp1_bit2: assert property (i_gpio_group1[2] |-> ##3 sts_reg[1][2])
    else $error("group one event not latched");
  a_grp1_bit3: assert property (i_gpio_group1[3] |-> ##3 sts_reg[1][3])
    else $error("group one event not latched");
  a_grp1_bit4: assert property (i_gpio_group1[4] |-> ##3 sts_reg[1][4])
    else $error("group one event not latched");
  a_grp1_bit5: assert property (i_gpio_group1[5] |-> ##3 sts_reg[1][5])
    else $error("group one event not latched");
  a_grp1_bit6: assert property (i_gpio_group1[6] |-> ##3 sts_reg[1][6])
    else $error("group one event not latched");
  a_grp1_bit7: assert property (i_gpio_group1[7] |-> ##3 sts_reg[1][7])
    else $error("group one event not latched");

  // group two register, bit 3 is the group smi status
  a_grp2_bit0: assert property (i_gpio_group2_low[0] |-> ##3 sts_reg[2][0])
    else $error("group two event not latched");
  a_grp2_bit1: assert property (i_gpio_group2_low[1] |-> ##3 sts_reg[2][1])
    else $error("group two event not latched");
  a_grp2_bit2: assert property (i_gpio_group2_low[2] |-> ##3 sts_reg[2][2])
    else $error("group two event not latched");
  a_smi_status_map: assert property (i_group_smi_wake_status |-> ##3 sts_reg[2][3])
    else $error("group two event not latched");
  a_grp2_bit4: assert property (i_gpio_group2_high[0] |-> ##3 sts_reg[2][4])
    else $error("group two event not latched");
  a_grp2_bit5: assert property (i_gpio_group2_high[1] |-> ##3 sts_reg[2][5])
    else $error("group two event not latched");
  a_grp2_bit6: assert property (i_gpio_group2_high[2] |-> ##3 sts_reg[2][6])
    else $error("group two event not latched");
  a_grp2_bit7: assert property (i_gpio_group2_high[3] |-> ##3 sts_reg[2][7])
    else $error("group two event not latched");

  // mixed register: groups three, four and six
  a_grp3_bit0: assert property (i_gpio_group3[0] |-> ##3 sts_reg[3][0])
    else $error("mixed event not latched");
  a_grp3_bit1: assert property (i_gpio_group3[1] |-> ##3 sts_reg[3][1])
    else $error("mixed event not latched");
  a_grp3_bit2: assert property (i_gpio_group3[2] |-> ##3 sts_reg[3][2])
    else $error("mixed event not latched");
  a_grp3_bit3: assert property (i_gpio_group3[3] |-> ##3 sts_reg[3][3])
    else $error("mixed event not latched");
  a_grp4_pin1: assert property (i_gpio_group4_pin1 |-> ##3 sts_reg[3][4])
    else $error("mixed event not latched");
  a_grp4_pin3: assert property (i_gpio_group4_pin3 |-> ##3 sts_reg[3][5])
    else $error("mixed event not latched");
  a_grp6_pin0: assert property (i_gpio_group6_pin0 |-> ##3 sts_reg[3][6])
    else $error("mixed event not latched");
  a_grp6_pin1: assert property (i_gpio_group6_pin1 |-> ##3 sts_reg[3][7])
    else $error("mixed event not latched");

  // group five register
  a_grp5_bit0: assert property (i_gpio_group5[0] |-> ##3 sts_reg[4][0])
    else $error("group five event not latched");
  a_grp5_bit1: assert property (i_gpio_group5[1] |-> ##3 sts_reg[4][1])
    else $error("group five event not latched");
  a_grp5_bit2: assert property (i_gpio_group5[2] |-> ##3 sts_reg[4][2])
    else $error("group five event not latched");
  a_grp5_bit3: assert property (i_gpio_group5[3] |-> ##3 sts_reg[4][3])
    else $error("group five event not latched");
  a_grp5_bit4: assert property (i_gpio_group5[4] |-> ##3 sts_reg[4][4])
    else $error("group five event not latched");
  a_grp5_bit5: assert property (i_gpio_group5[5] |-> ##3 sts_reg[4][5])
    else $error("group five event not latched");
  a_grp5_bit6: assert property (i_gpio_group5[6] |-> ##3 sts_reg[4][6])
    else $error("group five event not latched");
  a_grp5_bit7: assert property (i_gpio_group5[7] |-> ##3 sts_reg[4][7])
    else $error("group five event not latched");

  c_wake_asserted: cover property (out_en_reg ##1 !o_wake_request_n);
  c_flag_cleared: cover property (summary_reg && clr_summary ##1 !summary_reg);
  c_status_disabled_source: cover property (sts_reg[3][0] && !en_reg[3][0]);
  c_set_and_clear_same: cover property (wr_sts[1] && i_req.wdata[0] && sync2_reg[1][0]);
  c_flag_reset_pending: cover property (summary_reg && clr_summary && would_request ##2 summary_reg);

endmodule : wake_event_status_aggregator

// ### verilog/wake_agg_params.svh
// wake_agg_params.svh: offsets, reset values and field positions of the wake block
// assumes: included by the package, whose macros the design module uses; definitions only
`ifndef WAKE_AGG_PARAMS_SVH
`define WAKE_AGG_PARAMS_SVH

// register offsets within the runtime block
`define OFS_SUMMARY 4'h0
`define OFS_RSVD_ONE 4'h1
`define OFS_OUT_EN 4'h2
`define OFS_RSVD_THREE 4'h3
`define OFS_STS_DEVICES 4'h4
`define OFS_STS_GRP1 4'h5
`define OFS_STS_GRP2 4'h6
`define OFS_STS_MIXED 4'h7
`define OFS_STS_GRP5 4'h8
`define OFS_RSVD_NINE 4'h9
`define OFS_EN_DEVICES 4'hA
`define OFS_EN_GRP1 4'hB
`define OFS_EN_GRP2 4'hC
`define OFS_EN_MIXED 4'hD
`define OFS_EN_GRP5 4'hE

// reset values after standby-power power-on reset
`define RST_BYTE 8'h00
`define RST_BIT 1'b0

// field positions
`define FLAG_BIT 0
`define STS_DEV_RSVD_BIT 0

`endif

// ### verilog/wake_agg_pkg.sv
// wake_agg_pkg.sv: types shared by the wake block
// assumes: the params header is on the include path
package wake_agg_pkg;
  `include "wake_agg_params.svh"

  // number of eight-bit status and enable registers
  localparam int NUM_GROUPS = 5;

  // one byte-wide host register access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // raw wake event lines, one byte per status register
  typedef logic [NUM_GROUPS-1:0][7:0] wake_vec_t;
endpackage : wake_agg_pkg

// ### tb/wake_request_sink.sv
// wake_request_sink.sv: power-management side that watches the wake request line
// assumes: request is active low, synchronous to i_clk; host acknowledges by i_ack
`timescale 1ns/1ps

module wake_request_sink
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wake_request_n,
  input wire logic i_ack,
  output logic o_seen
);
  // latch any request until the host acknowledges it
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_seen <= 1'b0;
    else if (i_ack)
      o_seen <= 1'b0;
    else if (!i_wake_request_n)
      o_seen <= 1'b1;
  end
endmodule : wake_request_sink

// ### tb/wake_event_status_aggregator_tb_top.sv
// wake_event_status_aggregator_tb_top.sv: self-checking bench for the wake block
// assumes: design package, design and sink model compiled before this file
`timescale 1ns/1ps

module wake_event_status_aggregator_tb_top
  import wake_agg_pkg::*;
();
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  reg_req_t i_req = '0;
  logic [39:0] ev = '0;
  logic [7:0] o_rdata;
  logic o_wake_request_n;
  logic ack = 1'b0;
  logic seen;
  logic [7:0] d;
  logic [7:0] exp;
  int mismatches = 0;
  int compares = 0;

  wake_event_status_aggregator wake_event_status_aggregator_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata),
    .i_ring_indicate_port2(ev[1]), .i_ring_indicate_port1(ev[2]), .i_keyboard_wake(ev[3]),
    .i_mouse_wake(ev[4]), .i_specific_key_wake(ev[5]), .i_wake_a(ev[6]), .i_wake_b(ev[7]),
    .i_gpio_group1(ev[15:8]), .i_gpio_group2_low(ev[18:16]), .i_group_smi_wake_status(ev[19]),
    .i_gpio_group2_high(ev[23:20]), .i_gpio_group3(ev[27:24]), .i_gpio_group4_pin1(ev[28]),
    .i_gpio_group4_pin3(ev[29]), .i_gpio_group6_pin0(ev[30]), .i_gpio_group6_pin1(ev[31]),
    .i_gpio_group5(ev[39:32]), .o_wake_request_n(o_wake_request_n));

  wake_request_sink wake_request_sink_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wake_request_n(o_wake_request_n), .i_ack(ack), .o_seen(seen));

  // 40 MHz clock
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
    compares++;
    if (seen_v !== exp_v)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk) i_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge i_clk) i_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk) i_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_clk) i_req <= '0;
    #1 v = o_rdata;
  endtask : rd

  // event level held past the two-stage synchroniser, then removed
  task automatic pulse(input logic [39:0] v);
    @(posedge i_clk) ev <= v;
    repeat (4) @(posedge i_clk);
    ev <= '0;
    repeat (4) @(posedge i_clk);
  endtask : pulse

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    for (int a = 0; a < 15; a++)
    begin
      rd(4'(a), d);
      check("reset value", d, 8'h00);
    end
    check("request idle", {7'h00, o_wake_request_n}, 8'h01);
    $display("test reset_values done");
  endtask : reset_values

  // walking one over every source, then selective clearing
  task automatic status_map();
    for (int i = 0; i < 40; i++)
    begin
      pulse(40'h1 << i);
      exp = (i == 0) ? 8'h00 : 8'h01 << (i % 8);
      rd(4'(4 + i / 8), d);
      check("status bit", d, exp);
      check("request masked", {7'h00, o_wake_request_n}, 8'h01);
      wr(4'(4 + i / 8), exp);
      rd(4'(4 + i / 8), d);
      check("cleared bit", d, 8'h00);
    end
    pulse(40'hFF << 8);
    wr(4'h5, 8'h0F);
    rd(4'h5, d);
    check("partial clear", d, 8'hF0);
    wr(4'h5, 8'h00);
    rd(4'h5, d);
    check("zero write", d, 8'hF0);
    wr(4'h5, 8'hF0);
    rd(4'h5, d);
    check("full clear", d, 8'h00);
    $display("test status_map done");
  endtask : status_map

  // enable gating, summary flag and its clearing
  task automatic request_path();
    wr(4'hB, 8'h01);
    wr(4'h2, 8'hFF);
    rd(4'h2, d);
    check("out enable readback", d, 8'h01);
    wr(4'h2, 8'h00);
    pulse(40'h100);
    rd(4'h0, d);
    check("flag while disabled", d, 8'h01);
    check("request blocked", {7'h00, o_wake_request_n}, 8'h01);
    wr(4'h2, 8'h01);
    repeat (2) @(posedge i_clk);
    #1;
    check("request driven", {7'h00, o_wake_request_n}, 8'h00);
    check("sink saw request", {7'h00, seen}, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h0, d);
    check("flag zero write", d, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h01);
    repeat (2) @(posedge i_clk);
    rd(4'h0, d);
    check("flag cleared", d, 8'h00);
    check("request released", {7'h00, o_wake_request_n}, 8'h01);
    @(posedge i_clk) ack <= 1'b1;
    @(posedge i_clk) ack <= 1'b0;
    #1;
    check("sink acknowledged", {7'h00, seen}, 8'h00);
    $display("test request_path done");
  endtask : request_path

  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    summarize();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    reset_values();
    status_map();
    request_path();
    summarize();
  end
endmodule : wake_event_status_aggregator_tb_top
